// File: core/nibble_swap_xor_direction_load_op_exec.v
// Decode and one-cycle execute of nibble swap, two exclusive-ORs and direction load.
//
// Overview of operation
// - Swap nibbles of file register, flags untouched.
// - Swap result to W if d=0, else file.
// - XOR W with file register, update zero.
// - XOR result to W if d=0, else file.
// - Direction load copies W, no flags.
// - Direction load acts only for field 6.
`include "nibble_swap_xor_regs.vh"
module nibble_swap_xor_direction_load_op_exec (
	// Clock and reset.
	input  wire        CLK,
	input  wire        ARST_N,
	// Instruction issue.
	input  wire        INSN_VALID,
	input  wire [11:0] INSN,
	// File register read data for the addressed register.
	input  wire [7:0]  FILE_RDATA,
	// File register write port.
	output reg         FILE_WE,
	output reg  [4:0]  FILE_ADDR,
	output reg  [7:0]  FILE_WDATA,
	// Core state.
	output reg  [7:0]  WREG,
	output reg         ZFLAG,
	output reg  [7:0]  PORT_DIR,
	// Flags a word that none of the four handles, or a bad direction target.
	output reg         INSN_UNHANDLED
);
	reg        rst_meta_r;
	reg        rst_sync_r;
	wire       is_swap;
	wire       is_xor_reg;
	wire       is_xor_lit;
	wire       is_dir_load;
	wire       dest_file;
	wire [7:0] swap_res;
	wire [7:0] xreg_res;
	wire [7:0] xlit_res;

	// Reset release through two flops so that all state leaves reset on one edge.
	always @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	opcode_class u_class (
		.insn        (INSN),
		.is_swap     (is_swap),
		.is_xor_reg  (is_xor_reg),
		.is_xor_lit  (is_xor_lit),
		.is_dir_load (is_dir_load)
	);

	// Datapath results, formed in parallel; the class selects which one lands.
	assign dest_file = INSN[`DEST_BIT];
	assign swap_res  = {FILE_RDATA[3:0], FILE_RDATA[7:4]};
	assign xreg_res  = WREG ^ FILE_RDATA;
	assign xlit_res  = WREG ^ INSN[7:0];

	// Single-cycle execute. The write port is a one-cycle pulse, so the file
	// register sees exactly one write per qualifying instruction.
	always @(posedge CLK or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			FILE_WE        <= 1'b0;
			FILE_ADDR      <= 5'h0;
			FILE_WDATA     <= 8'h00;
			WREG           <= `WREG_RESET;
			ZFLAG          <= `ZFLAG_RESET;
			PORT_DIR       <= `DIR_RESET;
			INSN_UNHANDLED <= 1'b0;
		end else begin
			FILE_WE        <= 1'b0;
			INSN_UNHANDLED <= 1'b0;
			FILE_ADDR      <= INSN[`FADDR_MSB:0];
			if (INSN_VALID) begin
				if (is_swap) begin
					// Status flags are deliberately left alone here.
					if (dest_file) begin
						FILE_WE    <= 1'b1;
						FILE_WDATA <= swap_res;
					end else begin
						WREG <= swap_res;
					end
				end else if (is_xor_reg) begin
					ZFLAG <= (xreg_res == 8'h00);
					if (dest_file) begin
						FILE_WE    <= 1'b1;
						FILE_WDATA <= xreg_res;
					end else begin
						WREG <= xreg_res;
					end
				end else if (is_xor_lit) begin
					WREG  <= xlit_res;
					ZFLAG <= (xlit_res == 8'h00);
				end else if (is_dir_load) begin
					PORT_DIR <= WREG;
				end else begin
					// Covers other direction fields and foreign opcodes alike.
					INSN_UNHANDLED <= 1'b1;
				end
			end
		end
	end
endmodule // nibble_swap_xor_direction_load_op_exec

// File: core/nibble_swap_xor_regs.vh
// Opcode patterns, field positions and reset values for the four-instruction decode block.
`ifndef NIBBLE_SWAP_XOR_REGS_VH
`define NIBBLE_SWAP_XOR_REGS_VH
`define SWAP_MASK        12'hFC_0
`define SWAP_MATCH       12'h38_0
`define XORREG_MASK      12'hFC_0
`define XORREG_MATCH     12'h18_0
`define XORLIT_MASK      12'hF0_0
`define XORLIT_MATCH     12'hF0_0
`define DIRLD_MASK       12'hFF_8
`define DIRLD_MATCH      12'h00_0
`define DIRLD_PORT_SEL   3'h6
`define DEST_BIT         5
`define FADDR_MSB        4
`define WREG_RESET       8'h00
`define DIR_RESET        8'hFF
`define ZFLAG_RESET      1'b0
`endif

// File: core/opcode_class.v
// Combinational classifier that sorts a 12-bit instruction word into the four handled kinds.
`include "nibble_swap_xor_regs.vh"
module opcode_class (
	// Instruction word under decode.
	input  wire [11:0] insn,
	// One-hot class outputs.
	output wire        is_swap,
	output wire        is_xor_reg,
	output wire        is_xor_lit,
	output wire        is_dir_load
);
	// Mask-and-compare matching; unmatched words raise no class bit.
	assign is_swap     = (insn & `SWAP_MASK) == `SWAP_MATCH;
	assign is_xor_reg  = (insn & `XORREG_MASK) == `XORREG_MATCH;
	assign is_xor_lit  = (insn & `XORLIT_MASK) == `XORLIT_MATCH;
	assign is_dir_load = ((insn & `DIRLD_MASK) == `DIRLD_MATCH)
		&& (insn[2:0] == `DIRLD_PORT_SEL);
endmodule // opcode_class

// File: tb/exec_props.sv
// Checker for the swap, exclusive-OR and direction load block.
module exec_props (input logic CLK, ARST_N, INSN_VALID, FILE_WE, ZFLAG, INSN_UNHANDLED,
	input logic [11:0] INSN, input logic [4:0] FILE_ADDR,
	input logic [7:0] FILE_RDATA, FILE_WDATA, WREG, PORT_DIR);
	default clocking @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	// Issue of swap, register XOR and direction load words, qualified by the valid strobe.
	sequence sw; INSN_VALID && INSN[11:6] == 6'h0E; endsequence
	sequence xr; INSN_VALID && INSN[11:6] == 6'h06; endsequence
	sequence dl; INSN_VALID && INSN[11:3] == 9'h000; endsequence
	chk_swap_w: assert property (
		sw ##0 !INSN[5] |=> WREG == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])}
		&& $stable(ZFLAG)) else $error("swap to W");
	chk_swap_f: assert property (
		sw ##0 INSN[5] |=> FILE_WE && FILE_WDATA[3:0] == $past(FILE_RDATA[7:4])
		&& FILE_WDATA[7:4] == $past(FILE_RDATA[3:0]) && FILE_ADDR == $past(INSN[4:0])
		&& $stable(WREG)) else $error("swap to file");
	chk_xor_z: assert property (
		xr |=> ZFLAG == ($past(WREG) == $past(FILE_RDATA))) else $error("xor zero");
	chk_xor_dest: assert property (
		xr ##0 INSN[5] |=> FILE_WE && FILE_ADDR == $past(INSN[4:0])
		&& FILE_WDATA == ($past(WREG) ^ $past(FILE_RDATA))) else $error("xor to file");
	chk_dir_load: assert property (
		dl ##0 INSN[2:0] == 6 |=> PORT_DIR == $past(WREG) && $stable(ZFLAG)) else $error("dir");
	chk_dir_bad: assert property (
		dl ##0 INSN[2:0] != 6 |=> INSN_UNHANDLED && $stable(PORT_DIR)) else $error("dir bad");
	chk_xor_lit: assert property (
		INSN_VALID && INSN[11:8] == 4'hF |=> WREG == ($past(WREG) ^ $past(INSN[7:0]))
		&& ZFLAG == (WREG == 0)) else $error("xor literal");
endmodule // exec_props
bind nibble_swap_xor_direction_load_op_exec exec_props u_chk (.*);

// File: tb/tb_top.sv
// Self-checking bench for the swap, exclusive-OR and direction load block.
module tb_top;
	timeunit 1ns; timeprecision 1ns;
	logic CLK = 0, ARST_N = 0, v = 0;
	logic [11:0] ins = 0;
	logic [7:0] rd = 0;
	wire FILE_WE, ZFLAG, UNH;
	wire [4:0] FILE_ADDR;
	wire [7:0] FILE_WDATA, WREG, PORT_DIR;
	int n_errors = 0, samples_checked = 0;
	always #20 CLK = ~CLK;
	nibble_swap_xor_direction_load_op_exec u_dut (.CLK(CLK), .ARST_N(ARST_N), .INSN_VALID(v), .INSN(ins),
		.FILE_RDATA(rd), .FILE_WE(FILE_WE), .FILE_ADDR(FILE_ADDR), .FILE_WDATA(FILE_WDATA),
		.WREG(WREG), .ZFLAG(ZFLAG), .PORT_DIR(PORT_DIR), .INSN_UNHANDLED(UNH));
	// Results are registered, so they are read one edge after the word is taken.
	task ex(input logic [11:0] i, input logic [7:0] r);
		@(posedge CLK); v <= 1; ins <= i; rd <= r;
		@(posedge CLK); v <= 0; #1;
	endtask
	task ck(input logic [7:0] g, e);
		samples_checked++;
		if (g !== e) begin n_errors++; $display("ERROR %0t got %h want %h", $time, g, e); end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task t_lit;
		ck(PORT_DIR, 8'hFF); ex(12'hFB5, 0); ex(12'hFAF, 0);
		ck(WREG, 8'h1A); ck(8'(ZFLAG), 0);
		ex(12'hF1A, 0); ck(8'(ZFLAG), 1);
		$display("literal done");
	endtask
	task t_swap;
		ex(12'h385, 8'hA5); ck(WREG, 8'h5A); ck(8'(ZFLAG), 1);
		ex(12'h3A5, 8'hC3); ck(FILE_WDATA, 8'h3C); ck(8'(FILE_WE), 1); ck(WREG, 8'h5A);
		ck(8'(FILE_ADDR), 8'h05); @(posedge CLK); #1; ck(8'(FILE_WE), 0);
		$display("swap done");
	endtask
	task t_xor;
		ex(12'h1A3, 8'hAF); ck(FILE_WDATA, 8'hF5); ck(WREG, 8'h5A); ck(8'(ZFLAG), 0);
		ex(12'h183, 8'h5A); ck(WREG, 8'h00); ck(8'(ZFLAG), 1);
		$display("xor done");
	endtask
	task t_dir;
		ex(12'hFA5, 0); ex(12'h006, 0); ck(PORT_DIR, 8'hA5);
		ex(12'hFFF, 0); ex(12'h005, 0); ck(PORT_DIR, 8'hA5); ck(8'(UNH), 1);
		$display("direction done");
	endtask
	// Mid-run reset: state must clear at once and words resume after the release flops.
	task t_rst;
		@(posedge CLK); ARST_N <= 0; #1;
		ck(WREG, 8'h00); ck(PORT_DIR, 8'hFF); ck(8'(ZFLAG), 0);
		@(posedge CLK); ARST_N <= 1;
		repeat (3) @(posedge CLK);
		ex(12'hF3C, 0); ck(WREG, 8'h3C); ck(8'(ZFLAG), 0);
		$display("reset done");
	endtask
	// Reset for two cycles, then let the release flops settle before the first word.
	initial begin
		repeat (2) @(posedge CLK);
		ARST_N <= 1;
		repeat (3) @(posedge CLK);
		t_lit; t_swap; t_xor; t_dir; t_rst;
		end_sim;
	end
	initial begin #4000; n_errors++; end_sim; end
endmodule // tb_top
